//--- hw/slice_exec_pkg.sv
`default_nettype none
package slice_exec_pkg;
  // =======================================
  // Widths
  localparam int PC_W        = 21;
  localparam int SP_W        = 5;
  localparam int DMEM_AW     = 12;
  localparam int STACK_DEPTH = 31;
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
  localparam logic [SP_W-1:0] SP_FULL  = 5'h1f;
  localparam logic [SP_W-1:0] SP_ONE   = 5'h01;
  // =======================================
  // Register offsets
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_PC     = 8'h04;
  localparam logic [7:0] OFS_ACC    = 8'h08;
  localparam logic [7:0] OFS_FLAGS  = 8'h0c;
  localparam logic [7:0] OFS_BANK   = 8'h10;
  localparam logic [7:0] OFS_SHADOW = 8'h14;
  localparam logic [7:0] OFS_IRQ    = 8'h18;
  localparam logic [7:0] OFS_TOP    = 8'h1c;
  localparam logic [7:0] OFS_MADDR  = 8'h20;
  localparam logic [7:0] OFS_MDATA  = 8'h24;
  localparam logic [7:0] OFS_LATCH  = 8'h28;
  // =======================================
  // Field positions
  localparam int SP_LSB     = 8;
  localparam int SH_FL_LSB  = 8;
  localparam int SH_BSR_LSB = 16;
  localparam int IRQ_HI_BIT = 0;
  localparam int IRQ_LO_BIT = 1;
  localparam int LAT_UP_LSB = 8;
  localparam int FLAG_C     = 0;
  localparam int FLAG_DC    = 1;
  localparam int FLAG_Z     = 2;
  localparam int FLAG_OV    = 3;
  localparam int FLAG_N     = 4;
  localparam int FAST_BIT   = 0;
  localparam int ACCESS_BIT = 8;
  localparam int OFFS_MSB   = 10;
  // =======================================
  // Opcodes
  localparam logic [15:0] OP_POP      = 16'h0006;
  localparam logic [15:0] OP_PUSH     = 16'h0005;
  localparam logic [15:0] OP_RESET    = 16'h00ff;
  localparam logic [15:0] OP_RETURN_FROM_IRQ_OP   = 16'h0010;
  localparam logic [15:0] MSK_RETURN_FROM_IRQ_OP  = 16'hfffe;
  localparam logic [15:0] OP_RELATIVE_CALL_OP    = 16'hd800;
  localparam logic [15:0] MSK_RELATIVE_CALL_OP   = 16'hf800;
  localparam logic [15:0] OP_RETURN_WITH_LITERAL_OP    = 16'h0c00;
  localparam logic [15:0] MSK_RETURN_WITH_LITERAL_OP   = 16'hff00;
  localparam logic [15:0] OP_NEG      = 16'h6c00;
  localparam logic [15:0] MSK_NEG     = 16'hfe00;
  // =======================================
  // Reset values and constants
  localparam logic [PC_W-1:0] PC_RST  = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [7:0] BYTE_RST     = 8'h00;
  localparam logic [4:0] FLAGS_RST    = 5'h00;
  localparam logic [3:0] BANK_RST     = 4'h0;
  localparam logic [3:0] ACC_HI_BANK  = 4'hf;
  localparam logic [7:0] ACC_SPLIT    = 8'h80;
  localparam logic [7:0] NEG_MIN      = 8'h80;
  localparam logic [3:0] NIB_ZERO     = 4'h0;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_DECODE  = 5'b00010,
    ST_READ    = 5'b00100,
    ST_PROCESS = 5'b01000,
    ST_WRITE   = 5'b10000
  } phase_t;
endpackage : slice_exec_pkg
`default_nettype wire

//--- hw/slice_exec.sv
// Function
// - Negate writes two's complement back, sets flags
// - Access bit 0 forces access bank
// - Stack pop discards top entry, one cycle
// - Stack push stores PC+2, one cycle
// - Relative call pushes PC+2 first
// - Relative call jumps to PC+2+2n
// - Relative call takes two cycles
// - Software reset restores reset values, except the shadows, from phase two
// - Interrupt return pops PC, sets an enable
// - Fast bit restores accumulator, flags, bank
// - Interrupt return keeps latches, two cycles
// - Literal return loads accumulator, pops PC
// - Literal return keeps upper PC latches
`default_nettype none
module slice_exec (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  // Status
  output logic             busy,
  output logic             soft_reset_pulse
);
  // =======================================
  // Sequencer state
  slice_exec_pkg::phase_t                phase;
  slice_exec_pkg::phase_t                next_phase;
  logic                                  second;
  logic                                  next_second;
  logic [15:0]                           instr;
  logic [15:0]                           next_instr;
  logic [7:0]                            operand;
  logic [7:0]                            next_operand;
  logic                                  next_busy;
  logic                                  next_soft_reset_pulse;
  logic [31:0]                           next_rdata;

  // =======================================
  // Architectural state
  logic [slice_exec_pkg::PC_W-1:0]       pc;
  logic [slice_exec_pkg::PC_W-1:0]       next_pc;
  logic [7:0]                            acc;
  logic [7:0]                            next_acc;
  logic [4:0]                            flags;
  logic [4:0]                            next_flags;
  logic [3:0]                            bank_select_reg;
  logic [3:0]                            next_bank_select_reg;
  logic [7:0]                            accumulator_shadow;
  logic [7:0]                            next_accumulator_shadow;
  logic [4:0]                            flags_shadow;
  logic [4:0]                            next_flags_shadow;
  logic [3:0]                            bank_select_shadow;
  logic [3:0]                            next_bank_select_shadow;
  logic                                  high_priority_irq_enable;
  logic                                  next_high_priority_irq_enable;
  logic                                  low_priority_irq_enable;
  logic                                  next_low_priority_irq_enable;
  logic [slice_exec_pkg::SP_W-1:0]       sp;
  logic [slice_exec_pkg::SP_W-1:0]       next_sp;
  logic [7:0]                            pc_high_latch;
  logic [7:0]                            next_pc_high_latch;
  logic [slice_exec_pkg::PC_W-17:0]      pc_upper_latch;
  logic [slice_exec_pkg::PC_W-17:0]      next_pc_upper_latch;
  logic [slice_exec_pkg::DMEM_AW-1:0]    mem_addr;
  logic [slice_exec_pkg::DMEM_AW-1:0]    next_mem_addr;

  // =======================================
  // Storage
  logic [slice_exec_pkg::PC_W-1:0]       stack_entry [1:slice_exec_pkg::STACK_DEPTH];
  logic [slice_exec_pkg::PC_W-1:0]       stack_top_entry;
  logic                                  stack_wr;
  logic [slice_exec_pkg::SP_W-1:0]       stack_slot;
  logic [slice_exec_pkg::PC_W-1:0]       stack_value;
  logic [7:0]                            data_mem [0:(2**slice_exec_pkg::DMEM_AW)-1];
  logic                                  mem_wr;
  logic [slice_exec_pkg::DMEM_AW-1:0]    mem_wr_addr;
  logic [7:0]                            mem_wr_data;

  // =======================================
  // Decode helpers
  logic                                  is_neg;
  logic                                  is_pop;
  logic                                  is_push;
  logic                                  is_relative_call_op;
  logic                                  is_reset;
  logic                                  is_return_from_irq_op;
  logic                                  is_return_with_literal_op;
  logic                                  two_cycle;
  logic [slice_exec_pkg::DMEM_AW-1:0]    file_addr;
  logic [slice_exec_pkg::PC_W-1:0]       rel_offset;
  logic [7:0]                            neg_result;
  logic [31:0]                           shadow_word;
  logic [31:0]                           irq_word;
  logic [31:0]                           latch_word;

  assign is_neg    = (instr & slice_exec_pkg::MSK_NEG) == slice_exec_pkg::OP_NEG;
  assign is_pop    = instr == slice_exec_pkg::OP_POP;
  assign is_push   = instr == slice_exec_pkg::OP_PUSH;
  assign is_relative_call_op  = (instr & slice_exec_pkg::MSK_RELATIVE_CALL_OP) == slice_exec_pkg::OP_RELATIVE_CALL_OP;
  assign is_reset  = instr == slice_exec_pkg::OP_RESET;
  assign is_return_from_irq_op = (instr & slice_exec_pkg::MSK_RETURN_FROM_IRQ_OP) == slice_exec_pkg::OP_RETURN_FROM_IRQ_OP;
  assign is_return_with_literal_op  = (instr & slice_exec_pkg::MSK_RETURN_WITH_LITERAL_OP) == slice_exec_pkg::OP_RETURN_WITH_LITERAL_OP;
  assign two_cycle = is_relative_call_op | is_return_from_irq_op | is_return_with_literal_op;

  // Empty stack reads as zero rather than an unwritten slot
  assign stack_top_entry = (sp == slice_exec_pkg::SP_EMPTY) ? '0 : stack_entry[sp];

  // Word offset doubled, so targets stay even
  assign rel_offset = {{(slice_exec_pkg::PC_W - slice_exec_pkg::OFFS_MSB - 2)
                        {instr[slice_exec_pkg::OFFS_MSB]}},
                       instr[slice_exec_pkg::OFFS_MSB:0], 1'b0};

  assign neg_result = slice_exec_pkg::BYTE_RST - operand;

  always_comb begin
    if (instr[slice_exec_pkg::ACCESS_BIT]) begin
      file_addr = {bank_select_reg, instr[7:0]};
    end else if (instr[7:0] < slice_exec_pkg::ACC_SPLIT) begin
      file_addr = {slice_exec_pkg::NIB_ZERO, instr[7:0]};
    end else begin
      file_addr = {slice_exec_pkg::ACC_HI_BANK, instr[7:0]};
    end
  end

  always_comb begin
    shadow_word = '0;
    irq_word    = '0;
    latch_word  = '0;
    shadow_word[7:0] = accumulator_shadow;
    shadow_word[slice_exec_pkg::SH_FL_LSB +: 5] = flags_shadow;
    shadow_word[slice_exec_pkg::SH_BSR_LSB +: 4] = bank_select_shadow;
    irq_word[slice_exec_pkg::IRQ_HI_BIT] = high_priority_irq_enable;
    irq_word[slice_exec_pkg::IRQ_LO_BIT] = low_priority_irq_enable;
    irq_word[slice_exec_pkg::SP_LSB +: slice_exec_pkg::SP_W] = sp;
    latch_word[7:0] = pc_high_latch;
    latch_word[slice_exec_pkg::LAT_UP_LSB +: (slice_exec_pkg::PC_W - 16)] = pc_upper_latch;
  end

  // =======================================
  // Next-state logic
  // Register writes are refused while an instruction runs
  always_comb begin
    next_phase                    = phase;
    next_second                   = second;
    next_instr                    = instr;
    next_operand                  = operand;
    next_pc                       = pc;
    next_acc                      = acc;
    next_flags                    = flags;
    next_bank_select_reg          = bank_select_reg;
    next_accumulator_shadow       = accumulator_shadow;
    next_flags_shadow             = flags_shadow;
    next_bank_select_shadow       = bank_select_shadow;
    next_high_priority_irq_enable = high_priority_irq_enable;
    next_low_priority_irq_enable  = low_priority_irq_enable;
    next_sp                       = sp;
    next_pc_high_latch            = pc_high_latch;
    next_pc_upper_latch           = pc_upper_latch;
    next_mem_addr                 = mem_addr;
    next_soft_reset_pulse         = 1'b0;
    next_rdata                    = '0;
    stack_wr                      = 1'b0;
    stack_slot                    = sp;
    stack_value                   = '0;
    mem_wr                        = 1'b0;
    mem_wr_addr                   = mem_addr;
    mem_wr_data                   = '0;
    unique case (phase)
      slice_exec_pkg::ST_IDLE: begin
        if (bus_wr) begin
          case (bus_addr)
            slice_exec_pkg::OFS_INSTR: begin
              next_instr  = bus_wdata[15:0];
              next_second = 1'b0;
              next_phase  = slice_exec_pkg::ST_DECODE;
            end
            slice_exec_pkg::OFS_PC: begin
              next_pc = {bus_wdata[slice_exec_pkg::PC_W-1:1], 1'b0};
            end
            slice_exec_pkg::OFS_ACC: begin
              next_acc = bus_wdata[7:0];
            end
            slice_exec_pkg::OFS_FLAGS: begin
              next_flags = bus_wdata[4:0];
            end
            slice_exec_pkg::OFS_BANK: begin
              next_bank_select_reg = bus_wdata[3:0];
            end
            slice_exec_pkg::OFS_SHADOW: begin
              next_accumulator_shadow = bus_wdata[7:0];
              next_flags_shadow       = bus_wdata[slice_exec_pkg::SH_FL_LSB +: 5];
              next_bank_select_shadow = bus_wdata[slice_exec_pkg::SH_BSR_LSB +: 4];
            end
            slice_exec_pkg::OFS_IRQ: begin
              next_high_priority_irq_enable = bus_wdata[slice_exec_pkg::IRQ_HI_BIT];
              next_low_priority_irq_enable  = bus_wdata[slice_exec_pkg::IRQ_LO_BIT];
              next_sp = bus_wdata[slice_exec_pkg::SP_LSB +: slice_exec_pkg::SP_W];
            end
            slice_exec_pkg::OFS_TOP: begin
              // Top can only be edited when something is stacked
              stack_wr    = sp != slice_exec_pkg::SP_EMPTY;
              stack_value = bus_wdata[slice_exec_pkg::PC_W-1:0];
            end
            slice_exec_pkg::OFS_MADDR: begin
              next_mem_addr = bus_wdata[slice_exec_pkg::DMEM_AW-1:0];
            end
            slice_exec_pkg::OFS_MDATA: begin
              mem_wr      = 1'b1;
              mem_wr_data = bus_wdata[7:0];
            end
            slice_exec_pkg::OFS_LATCH: begin
              next_pc_high_latch  = bus_wdata[7:0];
              next_pc_upper_latch = bus_wdata[slice_exec_pkg::LAT_UP_LSB +:
                                              (slice_exec_pkg::PC_W - 16)];
            end
            default: begin
            end
          endcase
        end
      end
      slice_exec_pkg::ST_DECODE: begin
        next_phase = slice_exec_pkg::ST_READ;
      end
      slice_exec_pkg::ST_READ: begin
        next_phase = slice_exec_pkg::ST_PROCESS;
        if (!second) begin
          if (is_neg) begin
            next_operand = data_mem[file_addr];
          end
          // Push on a full stack is dropped, the entries stay intact
          if ((is_push || is_relative_call_op) && sp != slice_exec_pkg::SP_FULL) begin
            next_sp     = sp + slice_exec_pkg::SP_ONE;
            stack_wr    = 1'b1;
            stack_slot  = sp + slice_exec_pkg::SP_ONE;
            stack_value = pc + slice_exec_pkg::PC_STEP;
          end
          if (is_reset) begin
            next_pc                       = slice_exec_pkg::PC_RST;
            next_acc                      = slice_exec_pkg::BYTE_RST;
            next_flags                    = slice_exec_pkg::FLAGS_RST;
            next_bank_select_reg          = slice_exec_pkg::BANK_RST;
            next_sp                       = slice_exec_pkg::SP_EMPTY;
            next_high_priority_irq_enable = 1'b0;
            next_low_priority_irq_enable  = 1'b0;
            next_pc_high_latch            = slice_exec_pkg::BYTE_RST;
            next_pc_upper_latch           = '0;
            next_mem_addr                 = '0;
            next_soft_reset_pulse         = 1'b1;
          end
        end
      end
      slice_exec_pkg::ST_PROCESS: begin
        next_phase = slice_exec_pkg::ST_WRITE;
        if (!second && is_pop && sp != slice_exec_pkg::SP_EMPTY) begin
          next_sp = sp - slice_exec_pkg::SP_ONE;
        end
      end
      slice_exec_pkg::ST_WRITE: begin
        if (second || !two_cycle) begin
          next_phase = slice_exec_pkg::ST_IDLE;
        end else begin
          // Second cycle is an empty refetch cycle
          next_phase  = slice_exec_pkg::ST_DECODE;
          next_second = 1'b1;
        end
        if (!second) begin
          if (is_neg) begin
            mem_wr                         = 1'b1;
            mem_wr_addr                    = file_addr;
            mem_wr_data                    = neg_result;
            next_flags[slice_exec_pkg::FLAG_C]  = operand == slice_exec_pkg::BYTE_RST;
            next_flags[slice_exec_pkg::FLAG_DC] = operand[3:0] == slice_exec_pkg::NIB_ZERO;
            next_flags[slice_exec_pkg::FLAG_Z]  = neg_result == slice_exec_pkg::BYTE_RST;
            next_flags[slice_exec_pkg::FLAG_OV] = operand == slice_exec_pkg::NEG_MIN;
            next_flags[slice_exec_pkg::FLAG_N]  = neg_result[7];
            next_pc                        = pc + slice_exec_pkg::PC_STEP;
          end else if (is_relative_call_op) begin
            next_pc = pc + slice_exec_pkg::PC_STEP + rel_offset;
          end else if (is_return_from_irq_op || is_return_with_literal_op) begin
            // Latches are left alone on both returns
            next_pc = stack_top_entry;
            if (sp != slice_exec_pkg::SP_EMPTY) begin
              next_sp = sp - slice_exec_pkg::SP_ONE;
            end
            if (is_return_with_literal_op) begin
              next_acc = instr[7:0];
            end else begin
              // A cleared high enable means a high-priority return
              if (!high_priority_irq_enable) begin
                next_high_priority_irq_enable = 1'b1;
              end else begin
                next_low_priority_irq_enable = 1'b1;
              end
              if (instr[slice_exec_pkg::FAST_BIT]) begin
                next_acc             = accumulator_shadow;
                next_flags           = flags_shadow;
                next_bank_select_reg = bank_select_shadow;
              end
            end
          end else if (!is_reset) begin
            next_pc = pc + slice_exec_pkg::PC_STEP;
          end
        end
      end
    endcase
    if (bus_rd) begin
      case (bus_addr)
        slice_exec_pkg::OFS_INSTR:  next_rdata = 32'(instr);
        slice_exec_pkg::OFS_PC:     next_rdata = 32'(pc);
        slice_exec_pkg::OFS_ACC:    next_rdata = 32'(acc);
        slice_exec_pkg::OFS_FLAGS:  next_rdata = 32'(flags);
        slice_exec_pkg::OFS_BANK:   next_rdata = 32'(bank_select_reg);
        slice_exec_pkg::OFS_SHADOW: next_rdata = shadow_word;
        slice_exec_pkg::OFS_IRQ:    next_rdata = irq_word;
        slice_exec_pkg::OFS_TOP:    next_rdata = 32'(stack_top_entry);
        slice_exec_pkg::OFS_MADDR:  next_rdata = 32'(mem_addr);
        slice_exec_pkg::OFS_MDATA:  next_rdata = 32'(data_mem[mem_addr]);
        slice_exec_pkg::OFS_LATCH:  next_rdata = latch_word;
        default:                    next_rdata = '0;
      endcase
    end
    next_busy = next_phase != slice_exec_pkg::ST_IDLE;
  end

  // =======================================
  // Registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase                    <= slice_exec_pkg::ST_IDLE;
      second                   <= 1'b0;
      instr                    <= '0;
      operand                  <= slice_exec_pkg::BYTE_RST;
      busy                     <= 1'b0;
      soft_reset_pulse         <= 1'b0;
      bus_rdata                <= '0;
      pc                       <= slice_exec_pkg::PC_RST;
      acc                      <= slice_exec_pkg::BYTE_RST;
      flags                    <= slice_exec_pkg::FLAGS_RST;
      bank_select_reg          <= slice_exec_pkg::BANK_RST;
      accumulator_shadow       <= slice_exec_pkg::BYTE_RST;
      flags_shadow             <= slice_exec_pkg::FLAGS_RST;
      bank_select_shadow       <= slice_exec_pkg::BANK_RST;
      high_priority_irq_enable <= 1'b0;
      low_priority_irq_enable  <= 1'b0;
      sp                       <= slice_exec_pkg::SP_EMPTY;
      pc_high_latch            <= slice_exec_pkg::BYTE_RST;
      pc_upper_latch           <= '0;
      mem_addr                 <= '0;
    end else begin
      phase                    <= next_phase;
      second                   <= next_second;
      instr                    <= next_instr;
      operand                  <= next_operand;
      busy                     <= next_busy;
      soft_reset_pulse         <= next_soft_reset_pulse;
      bus_rdata                <= next_rdata;
      pc                       <= next_pc;
      acc                      <= next_acc;
      flags                    <= next_flags;
      bank_select_reg          <= next_bank_select_reg;
      accumulator_shadow       <= next_accumulator_shadow;
      flags_shadow             <= next_flags_shadow;
      bank_select_shadow       <= next_bank_select_shadow;
      high_priority_irq_enable <= next_high_priority_irq_enable;
      low_priority_irq_enable  <= next_low_priority_irq_enable;
      sp                       <= next_sp;
      pc_high_latch            <= next_pc_high_latch;
      pc_upper_latch           <= next_pc_upper_latch;
      mem_addr                 <= next_mem_addr;
    end
  end

  // =======================================
  // Return stack entries, kept out of reset to save area
  for (genvar i = 1; i <= slice_exec_pkg::STACK_DEPTH; i++) begin : g_stack
    always_ff @(posedge clk) begin
      if (stack_wr && stack_slot == slice_exec_pkg::SP_W'(i)) begin
        stack_entry[i] <= stack_value;
      end
    end
  end

  // =======================================
  // Data memory
  always_ff @(posedge clk) begin
    if (mem_wr) begin
      data_mem[mem_wr_addr] <= mem_wr_data;
    end
  end
endmodule : slice_exec
`default_nettype wire

//--- test/slice_exec_checker.sv
`default_nettype none
module slice_exec_checker (
  input wire logic        clk, sys_rst, bus_wr, bus_rd, busy, soft_reset_pulse,
  input wire logic [7:0]  bus_addr,
  input wire logic [31:0] bus_wdata, bus_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_pulse_one_cycle: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("reset pulse too long");
  a_pc_stays_even: assert property (bus_rd && bus_addr == slice_exec_pkg::OFS_PC |=> !bus_rdata[0])
    else $error("odd program counter");
  a_instr_starts_busy: assert property (bus_wr && bus_addr == slice_exec_pkg::OFS_INSTR && !busy |=> busy)
    else $error("instruction did not start");
  a_push_one_cycle: assert property (bus_wr && bus_addr == slice_exec_pkg::OFS_INSTR && !busy && bus_wdata[15:0] == slice_exec_pkg::OP_PUSH |=> busy[*4] ##1 !busy)
    else $error("push not one instruction cycle");
  a_return_with_literal_op_two_cycles: assert property (bus_wr && bus_addr == slice_exec_pkg::OFS_INSTR && !busy && (bus_wdata[15:0] & slice_exec_pkg::MSK_RETURN_WITH_LITERAL_OP) == slice_exec_pkg::OP_RETURN_WITH_LITERAL_OP |=> busy[*8] ##1 !busy)
    else $error("literal return not two cycles");
  a_reset_pulse_busy: assert property (soft_reset_pulse |-> busy)
    else $error("reset pulse outside instruction");
  a_busy_ends: assert property ($rose(busy) |-> ##[1:16] !busy)
    else $error("busy too long");
endmodule : slice_exec_checker
bind slice_exec slice_exec_checker u_slice_exec_checker (.*);
`default_nettype wire

//--- test/test_slice_exec.sv
`default_nettype none
module test_slice_exec;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0, rd_d = 0, busy, soft_reset_pulse;
  logic [7:0]  bus_addr = 0, lfsr = 8'h41;
  logic [31:0] bus_wdata = 0, bus_rdata, exp_q[$];
  int          miscompares = 0, total_checks = 0;
  slice_exec u_slice_exec (.*);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) rd_d <= bus_rd;
  // Read data stand one cycle only, so look mid-cycle
  always @(negedge clk) if (rd_d) check(exp_q.pop_front(), bus_rdata);
  function automatic logic [7:0] next_lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : next_lfsr
  task automatic check(input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin miscompares++; $display("Error %0t exp %h got %h", $time, e, g); end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
    @(posedge clk) bus_wr <= 1'b0;
    @(negedge clk);
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) begin miscompares++; disable stim; end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk) {bus_addr, bus_rd} <= {a, 1'b1};
    @(posedge clk) bus_rd <= 1'b0;
    $display("test at %h done", a);
  endtask : rd
  initial begin
    begin : stim
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(slice_exec_pkg::OFS_PC, 32'h0);
      wr(slice_exec_pkg::OFS_INSTR, {16'h0, slice_exec_pkg::OP_PUSH});
      rd(slice_exec_pkg::OFS_PC, 32'h2);
      rd(slice_exec_pkg::OFS_TOP, 32'h2);
      lfsr = next_lfsr(lfsr);
      wr(slice_exec_pkg::OFS_INSTR, {16'h0, 8'h0c, lfsr});
      rd(slice_exec_pkg::OFS_ACC, {24'h0, lfsr});
      rd(slice_exec_pkg::OFS_PC, 32'h2);
      wr(slice_exec_pkg::OFS_MADDR, 32'h5);
      wr(slice_exec_pkg::OFS_MDATA, {24'h0, lfsr});
      wr(slice_exec_pkg::OFS_INSTR, {16'h0, slice_exec_pkg::OP_NEG | 16'h0005});
      rd(slice_exec_pkg::OFS_MDATA, {24'h0, 8'h00 - lfsr});
      wr(slice_exec_pkg::OFS_INSTR, {16'h0, slice_exec_pkg::OP_RELATIVE_CALL_OP | 16'h0003});
      rd(slice_exec_pkg::OFS_PC, 32'hc);
      rd(slice_exec_pkg::OFS_TOP, 32'h6);
      wr(slice_exec_pkg::OFS_INSTR, {16'h0, slice_exec_pkg::OP_PUSH});
      wr(slice_exec_pkg::OFS_INSTR, {16'h0, slice_exec_pkg::OP_POP});
      rd(slice_exec_pkg::OFS_TOP, 32'h6);
      lfsr = next_lfsr(lfsr);
      wr(slice_exec_pkg::OFS_SHADOW, {24'h0, lfsr});
      wr(slice_exec_pkg::OFS_INSTR, {16'h0, slice_exec_pkg::OP_RETURN_FROM_IRQ_OP | 16'h0001});
      rd(slice_exec_pkg::OFS_PC, 32'h6);
      rd(slice_exec_pkg::OFS_ACC, {24'h0, lfsr});
      rd(slice_exec_pkg::OFS_FLAGS, 32'h0);
      rd(slice_exec_pkg::OFS_IRQ, 32'h1);
      wr(slice_exec_pkg::OFS_INSTR, {16'h0, slice_exec_pkg::OP_RESET});
      rd(slice_exec_pkg::OFS_PC, 32'h0);
      rd(slice_exec_pkg::OFS_ACC, 32'h0);
      repeat (2) @(posedge clk);
    end
    complete_run();
  end
endmodule : test_slice_exec
`default_nettype wire
